// file: hdl/eipd_params.svh
// Notes on behaviour
// R1 - Bit 4 enables the pin as an interrupt request input.
// R2 - Enabled pin gets an internal pull resistor unless pull disable is set.
// R3 - Bit 6 set with pin enabled turns the internal pull device off.
// R4 - Bit 5 polarity: 0 falling edge or low level, 1 rising or high.
// R5 - Rising polarity turns the optional pull into a pulldown.
// R6 - Bit 0 mode: 0 edge only, 1 edge plus matching level.
// R7 - Bit 3 reads as the event flag, set on detected events.
// R8 - Writing 1 to bit 2 clears the flag; it always reads 0.
// R9 - In level mode the flag cannot clear while the pin is asserted.
// R10 - Bit 1 enables the hardware interrupt request while flag is set.
// R11 - Pin is synchronised; no events while the pin function is disabled.
// R12 - Bit 7 reads as zero and ignores writes.
`ifndef EIPD_PARAMS_SVH
`define EIPD_PARAMS_SVH
`define EIPD_ADDR_W 2
`define EIPD_OFS_CTRL 2'h0
`define EIPD_OFS_STAT 2'h1
`define EIPD_OFS_MASK 2'h2
`define EIPD_BIT_MODE 0
`define EIPD_BIT_REQEN 1
`define EIPD_BIT_ACK 2
`define EIPD_BIT_FLAG 3
`define EIPD_BIT_PINEN 4
`define EIPD_BIT_POL 5
`define EIPD_BIT_PDD 6
`define EIPD_CTRL_RESET 8'h00
`define EIPD_EV_EVENT 0
`define EIPD_EV_OVERRUN 1
`define EIPD_NUM_EV 2
`endif

// file: hdl/eipd_pkg.sv
package eipd_pkg;
  typedef enum logic [1:0] {
    EIPD_PIN_OFF = 2'h0,
    EIPD_PIN_IDLE = 2'h1,
    EIPD_PIN_ACTIVE = 2'h3
  } eipd_pin_state_t;
endpackage

// file: hdl/eipd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eipd_sync (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: hdl/eipd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "eipd_params.svh"
module eipd_top import eipd_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [`EIPD_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Request pin and pull device
  input wire logic req_pin_in,
  output logic pull_up_en_out,
  output logic pull_down_en_out,
  // Interrupts
  output logic cpu_irq_out,
  output logic irq_out
);
  logic pin_s;
  logic pin_prev_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic flag_reg;
  logic flag_next;
  logic [`EIPD_NUM_EV-1:0] stat_reg;
  logic [`EIPD_NUM_EV-1:0] mask_reg;
  logic [`EIPD_NUM_EV-1:0] ev_vec;
  eipd_pin_state_t st_reg;
  eipd_pin_state_t st_next;
  wire mode_lvl = ctrl_reg[`EIPD_BIT_MODE];
  wire req_en = ctrl_reg[`EIPD_BIT_REQEN];
  wire pin_en = ctrl_reg[`EIPD_BIT_PINEN];
  wire pol = ctrl_reg[`EIPD_BIT_POL];
  wire pdd = ctrl_reg[`EIPD_BIT_PDD];
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `EIPD_OFS_CTRL);
  wire wr_stat = reg_wr_in && (reg_addr_in == `EIPD_OFS_STAT);
  wire wr_mask = reg_wr_in && (reg_addr_in == `EIPD_OFS_MASK);
  wire ack = wr_ctrl && reg_wdata_in[`EIPD_BIT_ACK];
  // R11 pin sync
  eipd_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in(req_pin_in),
    .sync_out(pin_s)
  );
  // R4 polarity view
  wire asserted = pol ? pin_s : ~pin_s;
  wire was_asserted = pol ? pin_prev_reg : ~pin_prev_reg;
  // R11 detection off at once when the pin function is cleared
  wire det_on = (st_reg != EIPD_PIN_OFF) && pin_en;
  // R11 edge compare, gated by enable
  wire edge_det = det_on && asserted && !was_asserted;
  // R6 level mode adds held level
  wire lvl_det = det_on && mode_lvl && asserted;
  wire event_det = edge_det || lvl_det;
  // R1 pin function state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      EIPD_PIN_OFF: begin
        if (pin_en) begin
          st_next = EIPD_PIN_IDLE;
        end
      end
      EIPD_PIN_IDLE: begin
        if (!pin_en) begin
          st_next = EIPD_PIN_OFF;
        end else if (asserted) begin
          st_next = EIPD_PIN_ACTIVE;
        end
      end
      EIPD_PIN_ACTIVE: begin
        if (!pin_en) begin
          st_next = EIPD_PIN_OFF;
        end else if (!asserted) begin
          st_next = EIPD_PIN_IDLE;
        end
      end
      default: st_next = EIPD_PIN_OFF;
    endcase
  end
  // R12 bit 7 and R8 ack bit never stored
  assign ctrl_next = wr_ctrl ?
    {1'b0, reg_wdata_in[6:4], 2'b00, reg_wdata_in[1:0]} : ctrl_reg;
  // R8 R9 ack clears, event wins
  assign flag_next = event_det ? 1'b1 : (ack ? 1'b0 : flag_reg);
  assign ev_vec[`EIPD_EV_EVENT] = event_det && !flag_reg;
  assign ev_vec[`EIPD_EV_OVERRUN] = edge_det && flag_reg && !ack;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `EIPD_CTRL_RESET;
      flag_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      st_reg <= EIPD_PIN_OFF;
    end else begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      pin_prev_reg <= pin_s;
      st_reg <= st_next;
    end
  end
  // Sticky status, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < `EIPD_NUM_EV; gi++) begin : g_stat
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          stat_reg[gi] <= 1'b0;
          mask_reg[gi] <= 1'b0;
        end else begin
          if (ev_vec[gi]) begin
            stat_reg[gi] <= 1'b1;
          end else if (wr_stat && reg_wdata_in[gi]) begin
            stat_reg[gi] <= 1'b0;
          end
          if (wr_mask) begin
            mask_reg[gi] <= reg_wdata_in[gi];
          end
        end
      end
    end
  endgenerate
  // R7 R8 readback
  wire [7:0] ctrl_view = {1'b0, ctrl_reg[6:4], flag_reg, 1'b0,
    ctrl_reg[1:0]};
  wire [7:0] rd_mux =
    (reg_addr_in == `EIPD_OFS_CTRL) ? ctrl_view :
    (reg_addr_in == `EIPD_OFS_STAT) ? {6'h00, stat_reg} :
    (reg_addr_in == `EIPD_OFS_MASK) ? {6'h00, mask_reg} : 8'h00;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
    end
  end
  // R2 R3 R5 pull device
  assign pull_up_en_out = pin_en && !pdd && !pol;
  assign pull_down_en_out = pin_en && !pdd && pol;
  // R10 request
  assign cpu_irq_out = req_en && flag_reg;
  assign irq_out = |(stat_reg & mask_reg);

  chk_ack_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ack && !event_det |=> !flag_reg) // R8
    else $error("ack did not clear flag");
  chk_level_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ack && lvl_det |=> flag_reg) // R9
    else $error("flag cleared while level asserted");
  chk_edge_sets: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pin_en && $past(pin_en) && $past(pin_en, 2) && (st_reg != EIPD_PIN_OFF)
    && pol && pin_s && !pin_prev_reg |=> flag_reg) // R4
    else $error("rising edge missed");
  chk_off_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !pin_en && !flag_reg && !ack ##1 !pin_en |-> !flag_reg) // R11
    else $error("event while disabled");
  chk_req_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reg_rd_in && (reg_addr_in == `EIPD_OFS_CTRL) |=>
    ($past(cpu_irq_out) == (reg_rdata_out[`EIPD_BIT_REQEN] &&
    reg_rdata_out[`EIPD_BIT_FLAG]))) // R10
    else $error("request mismatch");
  chk_pull_kind: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_ctrl && reg_wdata_in[4] && !reg_wdata_in[6] |=>
    (pull_down_en_out == $past(reg_wdata_in[5])) && 
    (pull_up_en_out != pull_down_en_out)) // R5
    else $error("pull kind wrong");
  chk_pull_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_ctrl && reg_wdata_in[6] |=> !pull_up_en_out && !pull_down_en_out) // R3
    else $error("pull not disabled");
  chk_bit7_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == `EIPD_OFS_CTRL |=> !reg_rdata_out[7]
    && !reg_rdata_out[2]) // R12
    else $error("reserved bit nonzero");
  chk_mode_edge: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !mode_lvl && ack && !edge_det |=> !flag_reg) // R6
    else $error("edge mode flag stuck");
endmodule
`default_nettype wire

// file: bench/eipd_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
module eipd_pin_src (
  // Clock
  input wire logic sys_clk_in,
  // Drive request
  input wire logic drive_en_in,
  input wire logic drive_val_in,
  // Pull devices of the detector
  input wire logic pull_up_en_in,
  input wire logic pull_down_en_in,
  // Pin
  output logic pin_out
);
  logic float_reg = 1'b0;
  // Released pin without a pull wanders every cycle
  always_ff @(posedge sys_clk_in) begin
    float_reg <= ~float_reg;
  end
  assign pin_out = drive_en_in ? drive_val_in :
    pull_up_en_in ? 1'b1 : pull_down_en_in ? 1'b0 : float_reg;
endmodule
`default_nettype wire

// file: bench/eipd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "eipd_params.svh"
module eipd_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`EIPD_ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic drv_en = 1'b1;
  logic drv_val = 1'b1;
  logic [7:0] rdata;
  logic pin, pu, pd, cpu_irq, irq;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  eipd_top i_eipd_top (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .req_pin_in(pin), .pull_up_en_out(pu),
    .pull_down_en_out(pd), .cpu_irq_out(cpu_irq), .irq_out(irq));
  eipd_pin_src i_eipd_pin_src (.sys_clk_in(clk), .drive_en_in(drv_en),
    .drive_val_in(drv_val), .pull_up_en_in(pu), .pull_down_en_in(pd),
    .pin_out(pin));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (n_compared > 0 && miscompares == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Pin change is flagged by the third edge; four edges are allowed
  task automatic drive(input logic v);
    @(posedge clk);
    drv_en <= 1'b1;
    drv_val <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    chk({4'h0, cpu_irq, irq, pu, pd}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_fall;
    wr(2'h0, 8'h92);
    chk({6'h0, pu, pd}, 8'h02);
    drive(1'b0);
    rd(2'h0, 8'h1A);
    chk({7'h0, cpu_irq}, 8'h01);
    wr(2'h0, 8'h16);
    rd(2'h0, 8'h12);
    $display("test falling edge done");
  endtask
  task automatic t_rise;
    wr(2'h0, 8'h70);
    chk({6'h0, pu, pd}, 8'h00);
    drive(1'b1);
    rd(2'h0, 8'h78);
    chk({7'h0, cpu_irq}, 8'h00);
    wr(2'h0, 8'h34);
    chk({6'h0, pu, pd}, 8'h01);
    drive(1'b0);
    rd(2'h0, 8'h30);
    $display("test rising edge done");
  endtask
  task automatic t_level;
    wr(2'h0, 8'h13);
    drive(1'b0);
    rd(2'h0, 8'h1B);
    wr(2'h0, 8'h17);
    rd(2'h0, 8'h1B);
    @(posedge clk);
    drv_en <= 1'b0;
    repeat (4) @(posedge clk);
    wr(2'h0, 8'h17);
    rd(2'h0, 8'h13);
    $display("test level done");
  endtask
  task automatic t_off;
    wr(2'h0, 8'h40);
    chk({6'h0, pu, pd}, 8'h00);
    drive(1'b0);
    drive(1'b1);
    drive(1'b0);
    rd(2'h0, 8'h40);
    $display("test disabled done");
  endtask
  task automatic t_status;
    drive(1'b1);
    wr(2'h2, 8'h03);
    wr(2'h0, 8'h12);
    wr(2'h1, 8'h03);
    rd(2'h1, 8'h00);
    drive(1'b0);
    drive(1'b1);
    drive(1'b0);
    rd(2'h1, 8'h03);
    chk({7'h0, irq}, 8'h01);
    wr(2'h2, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(2'h1, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(2'h1, 8'h02);
    $display("test status done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fall();
    t_rise();
    t_level();
    t_off();
    t_status();
    print_verdict();
  end
endmodule
`default_nettype wire
